/* File: uatx_regs.svh */
`ifndef UATX_REGS_SVH
`define UATX_REGS_SVH

// ****************************************
// timing
// ****************************************
`define UATX_CLK_PERIOD_NS    20
`define UATX_ICYC_CLKS        4
`define UATX_FLAG_VALID_ICYC  2'h2
`define UATX_ABD_PRESCALE     8

// ****************************************
// frame layout, measurement and fifo
// ****************************************
`define UATX_FRAME_W          12
`define UATX_START_BIT        1'h0
`define UATX_LINE_MARK        1'h1
`define UATX_LAST_IDX_BASE    4'h9
`define UATX_ABD_EDGES        5
`define UATX_ABD_CNT_MAX      16'hFFFF
`define UATX_FIFO_DEPTH       8

`endif

/* File: uatx_pkg.sv */
`default_nettype none
`include "uatx_regs.svh"

package uatx_pkg;

    typedef enum logic {
        UATX_TX_IDLE,
        UATX_TX_SHIFT
    } uatx_tx_e;

    typedef enum logic [1:0] {
        UATX_ABD_OFF,
        UATX_ABD_WAIT,
        UATX_ABD_COUNT
    } uatx_abd_e;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } uatx_char_s;

    typedef struct packed {
        logic        serial_port_on;
        logic        transmit_on;
        logic        sync_mode;
        logic        nine_bit;
        logic        two_stop;
        logic        rate_16bit;
        logic [15:0] rate_divisor_pair;
    } uatx_cfg_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic ovf_clear;
        logic rcv_rd;
    } uatx_abd_cmd_s;

    typedef struct packed {
        uatx_tx_e                  tx_st;
        logic [`UATX_FRAME_W-1:0]  frame;
        logic [3:0]                bit_idx;
        logic [3:0]                last_idx;
        logic [15:0]               div_cnt;
        uatx_char_s                hold;
        logic                      hold_full;
        logic [1:0]                wr_age;
        logic [1:0]                icyc;
        logic                      flag;
        logic                      rx_s1;
        logic                      rx_s2;
        logic                      rx_prev;
        uatx_abd_e                 abd_st;
        logic [2:0]                edges;
        logic [15:0]               abd_pre;
        logic [15:0]               abd_cnt;
        logic                      abd_ovf;
        logic                      rcv_flag;
        logic [15:0]               abd_result;
    } uatx_state_s;

endpackage

`default_nettype wire

/* File: uatx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uatx_regs.svh"

module uatx_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = `UATX_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least two");
    end
    if (W < 1) begin : g_bad_width
        $error("fifo width must be positive");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } uatx_fifo_s;

    uatx_fifo_s st;
    uatx_fifo_s nxt;
    logic       push;
    logic       pop;

    assign in_ready_o  = st.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = st.cnt != '0;
    assign out_data_o  = st.mem[st.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        nxt = st;
        if (push) begin
            nxt.mem[st.wp] = in_data_i;
            nxt.wp         = st.wp + AW'(1);
        end
        if (pop) begin
            nxt.rp = st.rp + AW'(1);
        end
        case ({push, pop})
            2'h2:    nxt.cnt = st.cnt + (AW+1)'(1);
            2'h1:    nxt.cnt = st.cnt - (AW+1)'(1);
            default: nxt.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_fifo_no_overrun: assert property (@(posedge clock_i) disable iff (rst_i)
        st.cnt == (AW+1)'(DEPTH) && !out_ready_i |=> st.cnt == (AW+1)'(DEPTH) && $stable(st.wp))
        else $error("fifo accepts data while full");
    cv_fifo_full: cover property (@(posedge clock_i) disable iff (rst_i)
        st.cnt == (AW+1)'(DEPTH));

endmodule // uatx_fifo

`default_nettype wire

/* File: uatx_top.sv */
// Function
// - line idles at mark; start bit is space, stop bits are mark
// - frame is start bit, eight or nine data bits, one or two stops
// - data bits leave least significant bit first
// - every bit on the line lasts exactly one bit period
// - bit period comes from a divider selectable as eight or sixteen bits
// - receive measurement counts on its own prescale, not the transmitter format and rate setting
// - no hardware parity; ninth bit is carried as software gives it
// - sending runs only with transmit on, async mode and port on
// - port on enables the unit and turns the line pin to output
// - turning transmit on sets the buffer free flag at once
// - a character reaching an idle shifter moves into it at once
// - queued character enters shifter right after stop bit, start follows
// - free flag clear only while transmit or port is off or sync mode is on, or while shifter busy and a character waits
// - free flag drops at the second instruction cycle boundary after a write, never within one cycle
// - free flag is read only; only the transmit enables and buffer state drive it
// - free flag ignores the interrupt mask; mask only gates the request
// - overflow flag sets if rate counter wraps before the fifth rise
// - after overflow the rate counter keeps counting to the fifth rise
// - fifth rise sets receive flag and stops the measurement
// - receive buffer read clears receive flag; software clears overflow
// - overflow flag cannot be cleared while measurement still runs
`timescale 1ns/1ps
`default_nettype none
`include "uatx_regs.svh"

module uatx_top
    import uatx_pkg::*;
#(
    parameter int ABD_PRESCALE = `UATX_ABD_PRESCALE,
    parameter int FIFO_DEPTH   = `UATX_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    // configuration
    input  wire uatx_cfg_s     cfg_i,
    input  wire logic          transmit_irq_mask_i,
    // character stream
    input  wire logic          char_valid_i,
    input  wire uatx_char_s    char_i,
    output logic               char_ready_o,
    // line pins
    output logic               transmit_clock_pin_o,
    output logic               transmit_clock_pin_oe_o,
    input  wire logic          rx_pin_i,
    // transmit status
    output logic               transmit_buffer_free_flag_o,
    output logic               transmit_irq_o,
    output logic               shifter_empty_o,
    // rate measurement
    input  wire uatx_abd_cmd_s abd_cmd_i,
    output logic               autobaud_run_o,
    output logic               autobaud_overflow_flag_o,
    output logic               receive_flag_o,
    output logic [15:0]        measured_rate_o
);
    if (ABD_PRESCALE < 1 || ABD_PRESCALE > 65536) begin : g_bad_pre
        $error("measurement prescale must lie in 1 to 65536");
    end

    uatx_state_s st;
    uatx_state_s nxt;
    logic        tx_active;
    logic [15:0] div_load;
    logic        icyc_tick;
    logic        bit_end;
    logic        do_load;
    logic        fifo_valid;
    uatx_char_s  fifo_data;
    logic        hold_take;
    logic        rise;
    logic        fall;
    logic        pre_tick;
    logic        fifth_edge;
    logic        ovf_set;

    // ****************************************
    // enables and buffering
    // ****************************************
    assign tx_active = cfg_i.transmit_on && !cfg_i.sync_mode && cfg_i.serial_port_on;
    assign div_load  = cfg_i.rate_16bit ? cfg_i.rate_divisor_pair
                                        : {8'h00, cfg_i.rate_divisor_pair[7:0]};
    assign icyc_tick = st.icyc == 2'(`UATX_ICYC_CLKS - 1);
    assign bit_end   = st.tx_st == UATX_TX_SHIFT && st.div_cnt == 16'h0000;
    // the fifo drains only into an empty holding buffer, so a busy line stalls the source
    assign hold_take = fifo_valid && !st.hold_full && tx_active;

    uatx_fifo #(
        .W     ($bits(uatx_char_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (char_valid_i),
        .in_data_i   (char_i),
        .in_ready_o  (char_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (hold_take)
    );

    // ****************************************
    // measurement edges
    // ****************************************
    assign rise       = st.rx_s2 && !st.rx_prev;
    assign fall       = !st.rx_s2 && st.rx_prev;
    assign pre_tick   = st.abd_pre == 16'(ABD_PRESCALE - 1);
    assign fifth_edge = st.abd_st == UATX_ABD_COUNT && rise
                        && st.edges == 3'(`UATX_ABD_EDGES - 1);
    assign ovf_set    = st.abd_st == UATX_ABD_COUNT && pre_tick
                        && st.abd_cnt == `UATX_ABD_CNT_MAX;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt      = st;
        do_load  = 1'b0;
        nxt.icyc = st.icyc + 2'h1;
        if (icyc_tick && st.wr_age != `UATX_FLAG_VALID_ICYC) begin
            nxt.wr_age = st.wr_age + 2'h1;
        end
        if (hold_take) begin
            nxt.hold      = fifo_data;
            nxt.hold_full = 1'b1;
            nxt.wr_age    = 2'h0;
        end
        case (st.tx_st)
            UATX_TX_IDLE: begin
                do_load = st.hold_full;
            end
            UATX_TX_SHIFT: begin
                if (st.div_cnt != 16'h0000) begin
                    nxt.div_cnt = st.div_cnt - 16'h0001;
                end else if (st.bit_idx == st.last_idx) begin
                    if (st.hold_full) begin
                        do_load = 1'b1;
                    end else begin
                        nxt.tx_st = UATX_TX_IDLE;
                        nxt.frame = '1;
                    end
                end else begin
                    nxt.frame   = {`UATX_LINE_MARK, st.frame[`UATX_FRAME_W-1:1]};
                    nxt.bit_idx = st.bit_idx + 4'h1;
                    nxt.div_cnt = div_load;
                end
            end
            default: begin
                nxt.tx_st = UATX_TX_IDLE;
            end
        endcase
        if (do_load) begin
            // ninth bit passes untouched; parity, if any, is the caller's business
            nxt.frame     = {{2{`UATX_LINE_MARK}},
                             cfg_i.nine_bit ? st.hold.ninth : `UATX_LINE_MARK,
                             st.hold.data, `UATX_START_BIT};
            nxt.last_idx  = `UATX_LAST_IDX_BASE + {3'h0, cfg_i.nine_bit}
                            + {3'h0, cfg_i.two_stop};
            nxt.bit_idx   = 4'h0;
            nxt.div_cnt   = div_load;
            nxt.tx_st     = UATX_TX_SHIFT;
            nxt.hold_full = 1'b0;
        end
        if (!tx_active) begin
            nxt.tx_st     = UATX_TX_IDLE;
            nxt.frame     = '1;
            nxt.hold_full = 1'b0;
            nxt.bit_idx   = 4'h0;
        end
        // the flag has no write path at all; it is rebuilt from buffer state each cycle
        nxt.flag = tx_active && !(nxt.hold_full && nxt.tx_st == UATX_TX_SHIFT
                   && nxt.wr_age == `UATX_FLAG_VALID_ICYC);

        nxt.rx_s1   = rx_pin_i;
        nxt.rx_s2   = st.rx_s1;
        nxt.rx_prev = st.rx_s2;
        case (st.abd_st)
            UATX_ABD_OFF: begin
                nxt.abd_st = UATX_ABD_OFF;
            end
            UATX_ABD_WAIT: begin
                if (fall) begin
                    nxt.abd_st  = UATX_ABD_COUNT;
                    nxt.abd_cnt = 16'h0000;
                    nxt.abd_pre = 16'h0000;
                end
            end
            UATX_ABD_COUNT: begin
                nxt.abd_pre = pre_tick ? 16'h0000 : st.abd_pre + 16'h0001;
                if (pre_tick) begin
                    nxt.abd_cnt = st.abd_cnt + 16'h0001;
                end
                if (rise) begin
                    nxt.edges = st.edges + 3'h1;
                end
                if (fifth_edge) begin
                    nxt.abd_st     = UATX_ABD_OFF;
                    nxt.abd_result = st.abd_cnt;
                end
            end
            default: begin
                nxt.abd_st = UATX_ABD_OFF;
            end
        endcase
        if (abd_cmd_i.stop) begin
            nxt.abd_st = UATX_ABD_OFF;
        end
        if (abd_cmd_i.start) begin
            nxt.abd_st = UATX_ABD_WAIT;
            nxt.edges  = 3'h0;
        end
        if (abd_cmd_i.ovf_clear && st.abd_st == UATX_ABD_OFF) begin
            nxt.abd_ovf = 1'b0;
        end
        if (ovf_set) begin
            nxt.abd_ovf = 1'b1;
        end
        if (abd_cmd_i.rcv_rd) begin
            nxt.rcv_flag = 1'b0;
        end
        if (fifth_edge) begin
            nxt.rcv_flag = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            // line and receive history start at their idle high level, so no false edge
            st         <= '0;
            st.frame   <= '1;
            st.rx_s1   <= 1'b1;
            st.rx_s2   <= 1'b1;
            st.rx_prev <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign transmit_clock_pin_o        = st.frame[0];
    assign transmit_clock_pin_oe_o     = cfg_i.serial_port_on;
    assign transmit_buffer_free_flag_o = st.flag;
    assign transmit_irq_o              = st.flag && transmit_irq_mask_i;
    assign shifter_empty_o             = st.tx_st == UATX_TX_IDLE;
    assign autobaud_run_o              = st.abd_st != UATX_ABD_OFF;
    assign autobaud_overflow_flag_o    = st.abd_ovf;
    assign receive_flag_o              = st.rcv_flag;
    assign measured_rate_o             = st.abd_result;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_line_idle_mark: assert property (
        st.tx_st == UATX_TX_IDLE |-> transmit_clock_pin_o)
        else $error("line not at mark while idle");
    a_start_lsb_first: assert property (
        do_load && tx_active |=> !transmit_clock_pin_o
            && st.frame[8:1] == $past(st.hold.data))
        else $error("start bit or data order wrong");
    a_bit_hold_time: assert property (
        st.tx_st == UATX_TX_SHIFT && st.div_cnt != 16'h0000 && tx_active
            |=> $stable(transmit_clock_pin_o))
        else $error("line changed inside a bit period");
    a_divider_width: assert property (
        do_load && tx_active |=> st.div_cnt == $past(div_load)
            && (!$past(cfg_i.rate_16bit) || st.div_cnt == $past(cfg_i.rate_divisor_pair)))
        else $error("bit divider loaded with wrong value");
    a_tx_gate: assert property (
        !tx_active |=> st.tx_st == UATX_TX_IDLE && !st.hold_full && transmit_clock_pin_o)
        else $error("transmitter active while disabled");
    a_idle_handoff: assert property (
        st.tx_st == UATX_TX_IDLE && st.hold_full && tx_active
            |=> st.tx_st == UATX_TX_SHIFT && !st.hold_full)
        else $error("idle shifter did not take character");
    a_stop_handoff: assert property (
        bit_end && st.bit_idx == st.last_idx && st.hold_full && tx_active
            |=> st.bit_idx == 4'h0 && !transmit_clock_pin_o && !st.hold_full)
        else $error("queued character not started after stop bit");
    a_flag_state: assert property (
        $past(tx_active) |-> transmit_buffer_free_flag_o
            == !(st.hold_full && st.tx_st == UATX_TX_SHIFT
                 && st.wr_age == `UATX_FLAG_VALID_ICYC))
        else $error("free flag does not match buffer state");
    a_flag_late_clear: assert property (
        $rose(st.hold_full) && st.tx_st == UATX_TX_SHIFT && tx_active
            |-> (transmit_buffer_free_flag_o || !$past(tx_active)) [*4])
        else $error("free flag cleared too early");
    a_ovf_on_wrap: assert property (
        ovf_set |=> autobaud_overflow_flag_o ##0 st.abd_cnt == 16'h0000)
        else $error("overflow not flagged on counter wrap");
    a_count_on: assert property (
        st.abd_st == UATX_ABD_COUNT && pre_tick && !fifth_edge
            && !abd_cmd_i.stop && !abd_cmd_i.start
            |=> st.abd_cnt == $past(st.abd_cnt) + 16'h0001)
        else $error("rate counter stopped before fifth rise");
    a_fifth_edge: assert property (
        fifth_edge && !abd_cmd_i.start |=> !autobaud_run_o && receive_flag_o
            && measured_rate_o == $past(st.abd_cnt))
        else $error("fifth rise did not finish measurement");
    a_rcv_clear: assert property (
        abd_cmd_i.rcv_rd && !fifth_edge |=> !receive_flag_o)
        else $error("receive flag not cleared by read");
    a_ovf_hold: assert property (
        autobaud_run_o && autobaud_overflow_flag_o |=> autobaud_overflow_flag_o)
        else $error("overflow cleared while measurement runs");
    a_unit_off: assert property (
        !cfg_i.serial_port_on |-> !transmit_clock_pin_oe_o ##1 shifter_empty_o)
        else $error("pin driven or shifter busy with port off");
    a_flag_on_enable: assert property (
        $rose(tx_active) |=> transmit_buffer_free_flag_o)
        else $error("free flag not set on enable");
    a_stop_before_idle: assert property (
        $rose(shifter_empty_o) && $past(tx_active)
            |-> $past(bit_end) && $past(st.bit_idx) == $past(st.last_idx))
        else $error("shifter idle before last stop bit");
    a_ninth_passes: assert property (
        do_load && tx_active && cfg_i.nine_bit |=> st.frame[9] == $past(st.hold.ninth))
        else $error("ninth bit altered");
    a_eight_bit_mark: assert property (
        do_load && tx_active && !cfg_i.nine_bit |=> st.frame[9])
        else $error("ninth position not mark in eight bit frame");
    a_ovf_clear_off: assert property (
        abd_cmd_i.ovf_clear && !autobaud_run_o |=> !autobaud_overflow_flag_o)
        else $error("overflow flag not cleared while idle");
    a_rcv_only_fifth: assert property (
        $rose(receive_flag_o) |-> $past(fifth_edge))
        else $error("receive flag set without fifth rise");
    a_run_end_cause: assert property (
        $fell(autobaud_run_o) |-> $past(fifth_edge) || $past(abd_cmd_i.stop))
        else $error("measurement stopped without cause");

    cv_back_to_back: cover property (
        bit_end && st.bit_idx == st.last_idx && st.hold_full && tx_active);
    cv_flag_low: cover property (!transmit_buffer_free_flag_o ##1 transmit_buffer_free_flag_o);
    cv_overflow: cover property (ovf_set);
    cv_measure_done: cover property (fifth_edge && autobaud_overflow_flag_o);

endmodule // uatx_top

`default_nettype wire

/* File: uatx_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// remote receiver: samples mid-bit, logs words and start times
// ****************************************
module uatx_rx_model (
    // clock
    input  wire logic        clock_i,
    // line
    input  wire logic        line_i,
    // format, shared with the sender
    input  wire logic [15:0] bit_clks_i,
    input  wire logic        nine_i,
    input  wire logic        two_stop_i
);
    logic [8:0] word_q[$];
    longint     start_q[$];
    int         err_cnt = 0;
    longint     cyc = 0;

    // sampled on the falling edge so the pin flop has settled
    always @(negedge clock_i) cyc <= cyc + 1;

    initial begin : rx_loop
        logic [8:0] w;
        forever begin
            @(negedge clock_i);
            if (line_i === 1'b0) begin
                start_q.push_back(cyc);
                w = '0;
                repeat (bit_clks_i / 2) @(negedge clock_i);
                if (line_i !== 1'b0) err_cnt++;
                for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                    repeat (bit_clks_i) @(negedge clock_i);
                    w[i] = line_i;
                end
                for (int s = 0; s < (two_stop_i ? 2 : 1); s++) begin
                    repeat (bit_clks_i) @(negedge clock_i);
                    if (line_i !== 1'b1) err_cnt++;
                end
                word_q.push_back(w);
            end
        end
    end
endmodule // uatx_rx_model

`default_nettype wire

/* File: uatx_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module uatx_tb_top
    import uatx_pkg::*;
;
    logic          clock_i = 1'b0;
    logic          rst_i = 1'b1;
    uatx_cfg_s     cfg = '0;
    logic          mask = 1'b0;
    logic          char_valid = 1'b0;
    uatx_char_s    char_w = '0;
    logic          rx_pin = 1'b1;
    uatx_abd_cmd_s cmd = '0;
    logic          ready, pin, oe, flag, irq, sh_empty, run, ovf, rcv;
    logic [15:0]   rate;
    logic [15:0]   bit_clks;
    int            error_cnt = 0;
    int            check_count = 0;

    // ****************************************
    // design and remote receiver
    // ****************************************
    uatx_top #(.ABD_PRESCALE(1), .FIFO_DEPTH(8)) uatx_top_i (
        .clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg), .transmit_irq_mask_i(mask),
        .char_valid_i(char_valid), .char_i(char_w), .char_ready_o(ready),
        .transmit_clock_pin_o(pin), .transmit_clock_pin_oe_o(oe), .rx_pin_i(rx_pin),
        .transmit_buffer_free_flag_o(flag), .transmit_irq_o(irq), .shifter_empty_o(sh_empty),
        .abd_cmd_i(cmd), .autobaud_run_o(run), .autobaud_overflow_flag_o(ovf),
        .receive_flag_o(rcv), .measured_rate_o(rate));

    uatx_rx_model uatx_rx_model_i (
        .clock_i(clock_i), .line_i(pin), .bit_clks_i(bit_clks),
        .nine_i(cfg.nine_bit), .two_stop_i(cfg.two_stop));

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ready is combinational from fifo state, so ready at the falling edge holds at the next rise
    task automatic push(input logic [8:0] w);
        @(negedge clock_i);
        char_valid = 1'b1;
        char_w = w;
        while (ready !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
        char_valid = 1'b0;
    endtask

    task automatic abd(input uatx_abd_cmd_s c);
        @(negedge clock_i);
        cmd = c;
        @(negedge clock_i);
        cmd = '0;
    endtask

    task automatic wait_rx(input int n);
        for (int i = 0; i < 20000 && uatx_rx_model_i.word_q.size() < n; i++) tick(1);
    endtask

    // check n words in order and back-to-back spacing of frames
    task automatic chk_rx(input logic [8:0] w[], input int frame_clks);
        longint t0;
        wait_rx(w.size());
        chk(16'(uatx_rx_model_i.word_q.size()), 16'(w.size()));
        t0 = uatx_rx_model_i.start_q.pop_front();
        foreach (w[i]) begin
            chk({7'h00, uatx_rx_model_i.word_q.pop_front()}, {7'h00, w[i]});
            if (i > 0) begin
                chk(16'(uatx_rx_model_i.start_q[0] - t0), 16'(frame_clks));
                t0 = uatx_rx_model_i.start_q.pop_front();
            end
        end
    endtask

    // rx pin: first low of first_low cycles, then lows and highs of 20 cycles, five rises in all
    task automatic rx_pulses(input int first_low);
        rx_pin = 1'b0;
        tick(first_low);
        for (int i = 0; i < 5; i++) begin
            rx_pin = 1'b1;
            tick(20);
            if (i < 4) rx_pin = 1'b0;
            if (i < 4) tick(20);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        bit_clks = 16'h0004;
        cfg.serial_port_on = 1'b1;
        cfg.rate_divisor_pair = 16'h7703; // upper byte ignored in 8-bit mode
        tick(2);
        rst_i = 1'b0;
        chk({pin, oe, flag, sh_empty, run, ovf, rcv, ready}, 16'h00D1);
        for (int i = 0; i < 8; i++) push(9'h035 + 9'(i * 16));
        chk(ready, 1'b0);
        cfg.transmit_on = 1'b1;
        for (int i = 0; i < 6; i++) begin
            tick(1);
            if (i > 0) chk(flag, 1'b1);
        end
        tick(30);
        chk({flag, irq, sh_empty}, 16'h0000);
        chk_rx('{9'h035, 9'h045, 9'h055, 9'h065, 9'h075, 9'h085, 9'h095, 9'h0A5}, 40);
        tick(50);
        mask = 1'b1;
        tick(1);
        chk({flag, irq, sh_empty, pin}, 16'h000F);
        // nine bits, two stops, sixteen-bit divisor
        cfg.nine_bit = 1'b1;
        cfg.two_stop = 1'b1;
        cfg.rate_16bit = 1'b1;
        cfg.rate_divisor_pair = 16'h0102;
        bit_clks = 16'h0103;
        push(9'h1A5);
        push(9'h0C3);
        mask = 1'b0;
        chk_rx('{9'h1A5, 9'h0C3}, 12 * 259);
        tick(3200);
        // sync mode holds the word back
        cfg = '{serial_port_on: 1'b1, transmit_on: 1'b1, sync_mode: 1'b1,
                rate_divisor_pair: 16'h0003, default: 1'b0};
        bit_clks = 16'h0004;
        push(9'h05A);
        tick(100);
        chk({14'(uatx_rx_model_i.word_q.size()), pin, sh_empty}, 16'h0003);
        cfg.sync_mode = 1'b0;
        chk_rx('{9'h05A}, 40);
        // rate measurement, normal end
        abd('{start: 1'b1, default: 1'b0});
        tick(3);
        chk(run, 1'b1);
        rx_pulses(20);
        tick(6);
        chk({run, rcv, ovf}, 16'h0002);
        chk(16'(rate > 16'd177 && rate < 16'd183), 16'h0001);
        abd('{rcv_rd: 1'b1, default: 1'b0});
        chk(rcv, 1'b0);
        // overflow, clear refused while running, count goes on
        abd('{start: 1'b1, default: 1'b0});
        tick(3);
        fork
            rx_pulses(65600);
            begin
                // clear is tried after the wrap but before any rise
                tick(65560);
                chk(ovf, 1'b1);
                abd('{ovf_clear: 1'b1, default: 1'b0});
                chk({run, ovf}, 16'h0003);
            end
        join
        tick(6);
        chk({run, rcv, ovf}, 16'h0003);
        chk(16'(rate > 16'd221 && rate < 16'd227), 16'h0001);
        abd('{ovf_clear: 1'b1, default: 1'b0});
        chk(ovf, 1'b0);
        // abort by stop
        abd('{start: 1'b1, default: 1'b0});
        abd('{stop: 1'b1, default: 1'b0});
        tick(2);
        chk(run, 1'b0);
        cfg.serial_port_on = 1'b0;
        tick(1);
        chk({oe, flag, sh_empty, pin}, 16'h0003);
        chk(16'(uatx_rx_model_i.err_cnt), 16'h0000);
        end_sim();
    end

    // runs take about 76k cycles; cut off before 100k
    initial begin
        repeat (95000) @(posedge clock_i);
        error_cnt++;
        end_sim();
    end
endmodule // uatx_tb_top

`default_nettype wire
